// ===== core/flash_register_command_control.sv
`timescale 1ns/1ns
`default_nettype none
module flash_register_command_control
  import flash_cmd_pkg::*;
#(
  // Identity bytes: arbitrary neutral values
  parameter logic [7:0] MAKER_CODE   = 8'h5A,
  parameter logic [7:0] MEMORY_TYPE  = 8'h11,
  parameter logic [7:0] DENSITY_CODE = 8'h22
)(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Flash pins
  input  wire logic       csN,
  input  wire logic       sclk,
  input  wire logic [7:0] sioIn,
  output logic      [7:0] sioOut,
  output logic      [7:0] sioOe,
  input  wire logic       resetPinN,
  input  wire logic       factoryLockStrap,
  // Mode settings
  input  wire logic       octalMode,
  input  wire logic       doubleRateOctalMode,
  input  wire logic [2:0] latencyField,
  input  wire logic       preamblePatternSelect,
  // Array engine events
  input  wire logic       arrayBusy,
  input  wire logic       eraseFailEvt,
  input  wire logic       programFailEvt,
  input  wire logic       opSuccessEvt,
  input  wire logic       eraseSuspendEvt,
  input  wire logic       eraseResumeEvt,
  input  wire logic       programSuspendEvt,
  input  wire logic       programResumeEvt,
  input  wire logic       opCompleteEvt,
  input  wire logic       securedOtpMode,
  input  wire logic       arrayAccessReq,
  // State outputs
  output logic            writeEnableLatch,
  output logic            writeInProgressFlag,
  output logic            customerLockdownBit,
  output logic            otpUpdateAllowed,
  output logic            arrayAccessGrant,
  output logic      [3:0] blockProtectBits
);
  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [11:0] syncA_q, syncB_q;
  logic        csPrev_q, sclkPrev_q;

  always_ff @(posedge clock)
  begin
    syncA_q <= {csN, sclk, resetPinN, factoryLockStrap, sioIn};
    syncB_q <= syncA_q;
    csPrev_q <= syncB_q[11];
    sclkPrev_q <= syncB_q[10];
  end

  logic       csS, sclkS, rpinS, strapS;
  logic [7:0] dataS;
  logic       sclkRise, sclkFall, csRise, ddr, inEdge, outEdge;
  assign csS = syncB_q[11];
  assign sclkS = syncB_q[10];
  assign rpinS = syncB_q[9];
  assign strapS = syncB_q[8];
  assign dataS = syncB_q[7:0];
  assign sclkRise = sclkS & ~sclkPrev_q & ~csS;
  assign sclkFall = ~sclkS & sclkPrev_q & ~csS;
  assign csRise = csS & ~csPrev_q;
  assign ddr = octalMode & doubleRateOctalMode;
  // DTR moves one unit on each clock edge
  assign inEdge = sclkRise | (ddr & sclkFall);
  assign outEdge = sclkFall | (ddr & sclkRise);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  frame_state_type state_q;
  cmd_type         pend_q;
  src_type         src_q;
  logic [5:0]  bitCnt_q;
  logic [23:0] inShift_q, outShift_q;
  logic [4:0]  outLeft_q, dummyLeft_q;
  logic [3:0]  preIdx_q;
  logic        wel_q, wip_q, lock_q, factory_q, strapTaken_q;
  logic [11:0] timer_q;
  logic [4:0]  status_q;
  logic [4:0]  config_q;
  logic        eFail_q, pFail_q, eSusp_q, pSusp_q;
  logic [7:0]  sioOut_q, sioOe_q;
  logic        grant_q;

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  logic [5:0]  unitBits, bitNext;
  logic [23:0] shiftNext;
  logic        opDone, isRead, ignoreOp, enterSend, wipDone;
  logic [7:0]  statusView, configView, securityView, regView;
  src_type     srcNext;

  assign unitBits = octalMode ? 6'h08 : 6'h01;
  assign bitNext = (bitCnt_q > 6'h30) ? bitCnt_q : bitCnt_q + unitBits;
  assign shiftNext = octalMode ? {inShift_q[15:0], dataS}
                               : {inShift_q[22:0], dataS[0]};
  assign opDone = (state_q == FR_OPCODE) && inEdge && (bitNext == LEN_OPCODE);
  assign wipDone = wip_q && (timer_q == 12'h001);

  always_comb
  begin
    isRead = 1'b1;
    srcNext = SRC_STATUS;
    case (shiftNext[7:0])
      OP_READ_IDENTITY: srcNext = SRC_ID;
      OP_READ_STATUS:   srcNext = SRC_STATUS;
      OP_READ_CONFIG:   srcNext = SRC_CONFIG;
      OP_READ_SECURITY: srcNext = SRC_SECURITY;
      default:          isRead = 1'b0;
    endcase
  end

  // Identity is not decoded at all during array work
  assign ignoreOp = (srcNext == SRC_ID) && arrayBusy;
  assign enterSend = (opDone && isRead && !ignoreOp && !octalMode) ||
                     (state_q == FR_DUMMY && sclkRise &&
                      dummyLeft_q == 5'h01);

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n || csS)
      state_q <= FR_IDLE;
    else
      case (state_q)
        FR_IDLE:   state_q <= FR_OPCODE;
        FR_OPCODE:
          if (opDone)
          begin
            if (isRead && ignoreOp)
              state_q <= FR_IGNORE;
            else if (isRead)
              state_q <= octalMode ? FR_DUMMY : FR_SEND;
            else if (shiftNext[7:0] == OP_SET_WRITE_LATCH ||
                     shiftNext[7:0] == OP_CLEAR_WRITE_LATCH ||
                     shiftNext[7:0] == OP_WRITE_STATUS_CFG ||
                     shiftNext[7:0] == OP_WRITE_SECURITY)
              state_q <= FR_WDATA;
            else
              state_q <= FR_IGNORE;
          end
        FR_DUMMY:  if (enterSend) state_q <= FR_SEND;
        FR_SEND, FR_WDATA, FR_IGNORE: state_q <= state_q;
        default:   state_q <= FR_IDLE;
      endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n || state_q == FR_IDLE)
    begin
      bitCnt_q <= 6'h00;
      inShift_q <= 24'h00_0000;
    end
    else if (inEdge && (state_q == FR_OPCODE || state_q == FR_WDATA))
    begin
      bitCnt_q <= bitNext;
      inShift_q <= shiftNext;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n || state_q == FR_IDLE)
      pend_q <= CMD_NONE;
    else if (opDone)
      case (shiftNext[7:0])
        OP_SET_WRITE_LATCH:   pend_q <= CMD_SET_WEL;
        OP_CLEAR_WRITE_LATCH: pend_q <= CMD_CLR_WEL;
        OP_WRITE_STATUS_CFG:  pend_q <= CMD_WRITE_REGS;
        OP_WRITE_SECURITY:    pend_q <= CMD_WRITE_SEC;
        default:              pend_q <= CMD_NONE;
      endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      src_q <= SRC_STATUS;
    else if (opDone)
      src_q <= srcNext;
  end

  // ----------------------------------------------------------------
  // Frame end checks
  // ----------------------------------------------------------------
  logic frameOk8, lenOkRegs, acceptRegs, acceptSec, acceptSet, acceptClr;
  assign frameOk8 = (bitCnt_q == LEN_OPCODE);
  // DTR frames must also close with the clock low
  assign lenOkRegs = (bitCnt_q == LEN_ONE_BYTE || bitCnt_q == LEN_TWO_BYTE)
                     && !(ddr && sclkS);
  assign acceptRegs = csRise && pend_q == CMD_WRITE_REGS && lenOkRegs &&
                      wel_q && !wip_q;
  assign acceptSec = csRise && pend_q == CMD_WRITE_SEC && frameOk8 &&
                     wel_q && !wip_q && !lock_q;
  assign acceptSet = csRise && pend_q == CMD_SET_WEL && frameOk8 && !wip_q;
  assign acceptClr = csRise && pend_q == CMD_CLR_WEL && frameOk8;

  // ----------------------------------------------------------------
  // Write enable latch and timed register write
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n || !rpinS)
      wel_q <= 1'b0;
    else if (acceptSet)
      wel_q <= 1'b1;
    else if (acceptClr)
      wel_q <= 1'b0;
    else if (opCompleteEvt || wipDone || acceptSec)
      wel_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wip_q <= 1'b0;
      timer_q <= 12'h000;
    end
    else if (acceptRegs)
    begin
      wip_q <= 1'b1;
      timer_q <= 12'(REG_WRITE_CYCLES);
    end
    else if (wip_q)
    begin
      timer_q <= timer_q - 12'h001;
      if (wipDone)
        wip_q <= 1'b0;
    end
  end

  // Latch and progress bits are not stored here, so a write cannot touch them
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      status_q <= STATUS_RESET;
      config_q <= CONFIG_RESET;
    end
    else if (acceptRegs)
    begin
      status_q <= (bitCnt_q == LEN_TWO_BYTE) ?
                  {inShift_q[15], inShift_q[13:10]} :
                  {inShift_q[7], inShift_q[5:2]};
      if (bitCnt_q == LEN_TWO_BYTE)
        // Top/bottom is one-time: it can be set but never cleared
        config_q <= {inShift_q[CFG_PREAMBLE_EN],
                     inShift_q[CFG_TOP_BOTTOM] | config_q[CFG_TOP_BOTTOM],
                     inShift_q[2:0]};
    end
  end

  // ----------------------------------------------------------------
  // Security register flags
  // ----------------------------------------------------------------
  // Events win over clears in the same cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      eFail_q <= 1'b0;
      pFail_q <= 1'b0;
      eSusp_q <= 1'b0;
      pSusp_q <= 1'b0;
    end
    else
    begin
      eFail_q <= eraseFailEvt | (eFail_q & ~opSuccessEvt);
      pFail_q <= programFailEvt | (pFail_q & ~opSuccessEvt);
      eSusp_q <= eraseSuspendEvt | (eSusp_q & ~eraseResumeEvt);
      pSusp_q <= programSuspendEvt | (pSusp_q & ~programResumeEvt);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      lock_q <= 1'b0;
    else if (acceptSec)
      lock_q <= 1'b1;
  end

  // Strap is caught once, on the first cycle after reset release
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      strapTaken_q <= 1'b0;
      factory_q <= 1'b0;
    end
    else if (!strapTaken_q)
    begin
      strapTaken_q <= 1'b1;
      factory_q <= strapS;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      grant_q <= 1'b0;
    else
      grant_q <= arrayAccessReq & ~securedOtpMode;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign statusView = {status_q[4], 1'b0, status_q[3:0], wel_q, wip_q};
  assign configView = {3'h0, config_q};
  assign securityView = {1'b0, eFail_q, pFail_q, 1'b0, eSusp_q, pSusp_q,
                         lock_q, factory_q};

  always_comb
  begin
    case (enterSend && state_q == FR_OPCODE ? srcNext : src_q)
      SRC_STATUS: regView = statusView;
      SRC_CONFIG: regView = configView;
      default:    regView = securityView;
    endcase
  end

  logic useId;
  assign useId = (enterSend && state_q == FR_OPCODE) ? srcNext == SRC_ID
                                                      : src_q == SRC_ID;

  // Registers reload at each byte, so polling sees live values
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      outShift_q <= 24'h00_0000;
      outLeft_q <= 5'h00;
    end
    else if (enterSend || (state_q == FR_SEND && outEdge &&
                           outLeft_q == 5'(unitBits)))
    begin
      outShift_q <= useId ? {MAKER_CODE, MEMORY_TYPE, DENSITY_CODE}
                          : {regView, 16'h0000};
      outLeft_q <= useId ? ID_BITS : REG_BITS;
    end
    else if (state_q == FR_SEND && outEdge)
    begin
      outShift_q <= octalMode ? {outShift_q[15:0], 8'h00}
                              : {outShift_q[22:0], 1'b0};
      outLeft_q <= outLeft_q - 5'(unitBits);
    end
  end

  // ----------------------------------------------------------------
  // Dummy cycles and preamble
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      dummyLeft_q <= 5'h00;
      preIdx_q <= 4'h0;
    end
    else if (opDone)
    begin
      dummyLeft_q <= DUMMY_TABLE[latencyField];
      preIdx_q <= 4'h0;
    end
    else if (state_q == FR_DUMMY)
    begin
      if (sclkRise)
        dummyLeft_q <= dummyLeft_q - 5'h01;
      if (outEdge)
        preIdx_q <= preIdx_q + 4'h1;
    end
  end

  logic preMain, preLine3;
  assign preMain = preamblePatternSelect ? PREAMBLE_ALT[4'hF - preIdx_q]
                                         : PREAMBLE_MAIN[4'hF - preIdx_q];
  assign preLine3 = preamblePatternSelect ? PREAMBLE_ALT[4'hF - preIdx_q]
                                          : PREAMBLE_LINE3[4'hF - preIdx_q];

  always_ff @(posedge clock)
  begin
    if (!rst_n || csS || state_q == FR_IDLE)
    begin
      sioOut_q <= 8'h00;
      sioOe_q <= 8'h00;
    end
    else if (state_q == FR_DUMMY && outEdge)
    begin
      // Pattern only when enabled; lines float otherwise
      sioOe_q <= {8{config_q[CFG_PREAMBLE_EN]}};
      sioOut_q <= {{4{preMain}}, preLine3, {3{preMain}}};
    end
    else if (state_q == FR_SEND && outEdge)
    begin
      sioOe_q <= octalMode ? 8'hFF : 8'h02;
      sioOut_q <= octalMode ? outShift_q[23:16] : {6'h00, outShift_q[23], 1'b0};
    end
  end

  assign sioOut = sioOut_q;
  assign sioOe = sioOe_q;
  assign writeEnableLatch = wel_q;
  assign writeInProgressFlag = wip_q;
  assign customerLockdownBit = lock_q;
  assign arrayAccessGrant = grant_q;
  assign blockProtectBits = status_q[3:0];

  logic otpOk_q;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      otpOk_q <= 1'b1;
    else
      otpOk_q <= ~lock_q;
  end
  assign otpUpdateAllowed = otpOk_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_dummy_count: assert property (opDone && isRead && octalMode && !ignoreOp |=>
    dummyLeft_q == DUMMY_TABLE[$past(latencyField)]) else $error("dummy count");
  a_preamble_off: assert property (state_q == FR_DUMMY && !config_q[4] |->
    ##1 sioOe_q == 8'h00) else $error("preamble driven while disabled");
  a_preamble_bits: assert property (state_q == FR_DUMMY && outEdge && !csS &&
    config_q[4] && !preamblePatternSelect |=> sioOut_q[0] ==
    PREAMBLE_MAIN[4'hF - $past(preIdx_q)]) else $error("preamble bit");
  a_erase_fail: assert property (eraseFailEvt |=> eFail_q)
    else $error("erase fail lost");
  a_prog_fail: assert property (programFailEvt |=> pFail_q ##1
    (pFail_q || $past(opSuccessEvt))) else $error("program fail lost");
  a_suspend_bits: assert property (eraseSuspendEvt && programSuspendEvt |=>
    eSusp_q && pSusp_q) else $error("suspend flag");
  a_lock_sticky: assert property (lock_q |=> lock_q && !otpUpdateAllowed)
    else $error("lockdown lost");
  a_otp_block: assert property (securedOtpMode |=> !arrayAccessGrant)
    else $error("array granted in otp mode");
  a_latch_clear: assert property (acceptClr |=> !wel_q)
    else $error("latch not cleared");
  a_op_clear: assert property (opCompleteEvt && !acceptSet |=> !wel_q)
    else $error("latch kept after completion");
  a_id_ignored: assert property (opDone && shiftNext[7:0] == OP_READ_IDENTITY
    && arrayBusy |=> (state_q == FR_IGNORE) [*2] or csS) else $error("id decoded");
  a_reject_write: assert property (csRise && pend_q == CMD_WRITE_REGS &&
    !lenOkRegs |=> !$rose(wip_q) && $stable(status_q) && $stable(config_q))
    else $error("bad frame accepted");
  a_wip_hold: assert property (acceptRegs |=> wip_q [*8])
    else $error("write cycle too short");
  a_wip_end: assert property (wipDone |=> !wip_q && !wel_q)
    else $error("write cycle end");

  c_reg_write: cover property (acceptRegs ##[1:1000] wipDone);
  c_id_read: cover property (enterSend && srcNext == SRC_ID);
  c_preamble: cover property (state_q == FR_DUMMY && config_q[4] && outEdge);
  c_reject: cover property (csRise && pend_q == CMD_WRITE_REGS && !lenOkRegs);
endmodule
`default_nettype wire

// ===== inc/flash_cmd_pkg.sv
package flash_cmd_pkg;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_WRITE_LATCH   = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_IDENTITY     = 8'h9F;
  localparam logic [7:0] OP_READ_STATUS       = 8'h05;
  localparam logic [7:0] OP_READ_CONFIG       = 8'h15;
  localparam logic [7:0] OP_READ_SECURITY     = 8'h2B;
  localparam logic [7:0] OP_WRITE_STATUS_CFG  = 8'h01;
  localparam logic [7:0] OP_WRITE_SECURITY    = 8'h2F;
  // ----------------------------------------------------------------
  // Register fields and reset values
  // ----------------------------------------------------------------
  localparam int SEC_ERASE_FAIL   = 6;
  localparam int SEC_PROGRAM_FAIL = 5;
  localparam int SEC_ERASE_SUSP   = 3;
  localparam int SEC_PROGRAM_SUSP = 2;
  localparam int SEC_LOCKDOWN     = 1;
  localparam int SEC_FACTORY_LOCK = 0;
  localparam int ST_STATUS_WR_DIS = 7;
  localparam int ST_BP_HI         = 5;
  localparam int ST_BP_LO         = 2;
  localparam int CFG_PREAMBLE_EN  = 4;
  localparam int CFG_TOP_BOTTOM   = 3;
  localparam logic [4:0] CONFIG_RESET = 5'h07;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  // ----------------------------------------------------------------
  // Frame lengths in data bits, opcode included; read data lengths (ID_BITS, REG_BITS) without it
  // ----------------------------------------------------------------
  localparam logic [5:0] LEN_OPCODE   = 6'h08;
  localparam logic [5:0] LEN_ONE_BYTE = 6'h10;
  localparam logic [5:0] LEN_TWO_BYTE = 6'h18;
  localparam logic [4:0] ID_BITS      = 5'h18;
  localparam logic [4:0] REG_BITS     = 5'h08;
  // ----------------------------------------------------------------
  // Dummy cycles per latency setting, preamble patterns
  // ----------------------------------------------------------------
  localparam logic [4:0] DUMMY_TABLE [8] = '{5'h14, 5'h12, 5'h10, 5'h0E,
                                             5'h0C, 5'h0A, 5'h08, 5'h06};
  localparam logic [15:0] PREAMBLE_MAIN  = 16'h349A;
  localparam logic [15:0] PREAMBLE_LINE3 = 16'h3514;
  localparam logic [15:0] PREAMBLE_ALT   = 16'h5555;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS   = 40;
  localparam int REG_WRITE_TIME_NS = 40000;
  localparam int REG_WRITE_CYCLES  =
    (REG_WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {FR_IDLE, FR_OPCODE, FR_DUMMY, FR_SEND,
                            FR_WDATA, FR_IGNORE} frame_state_type;
  typedef enum logic [2:0] {CMD_NONE, CMD_SET_WEL, CMD_CLR_WEL,
                            CMD_WRITE_REGS, CMD_WRITE_SEC} cmd_type;
  typedef enum logic [1:0] {SRC_ID, SRC_STATUS, SRC_CONFIG,
                            SRC_SECURITY} src_type;
endpackage

// ===== dv/host_spi_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_spi_model (
  // Clock and device output
  input  wire logic       clock,
  input  wire logic [7:0] sioOut,
  input  wire logic [7:0] sioOe,
  input  wire logic       octal,
  // Host-driven pins
  output logic            csN,
  output logic            sclk,
  output logic      [7:0] sioIn
);
  // ------
  // Whole frames; sclk idles low, csN rises only with sclk low
  // ------
  // Octal frames carry only the opcode byte, then idle lines
  logic [7:0] lastByte, lastOe;
  task automatic frame(input logic [31:0] tx, input int n,
                       output logic [31:0] rx);
    rx = '0;
    csN = 1'b0;
    repeat (4) @(negedge clock);
    for (int i = 0; i < n; i++)
    begin
      sioIn = octal ? (i == 0 ? tx[31:24] : 8'h00) : {7'h00, tx[31-i]};
      sclk = 1'b0;
      repeat (4) @(negedge clock);
      sclk = 1'b1;
      repeat (4) @(negedge clock);
      // Late in the high phase, well after the falling-edge update
      rx = {rx[30:0], sioOut[1]};
      lastByte = sioOut;
      lastOe = sioOe;
    end
    sclk = 1'b0;
    repeat (4) @(negedge clock);
    csN = 1'b1;
    sioIn = ~sioIn;
    repeat (12) @(negedge clock);
  endtask
  initial
  begin
    csN = 1'b1;
    sclk = 1'b0;
    sioIn = 8'h00;
  end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import flash_cmd_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        csN, sclk, resetPinN = 1'b1, strap = 1'b1;
  logic        octal = 1'b0, dtr = 1'b0, patSel = 1'b0, busy = 1'b0;
  logic [2:0]  latency = 3'h0;
  logic [7:0]  sioIn, sioOut, sioOe, ev = 8'h00;
  logic        otpMode = 1'b0, accessReq = 1'b0;
  logic        write_enable_latch, write_in_progress_flag, lockdown, otpOk, grant;
  logic [3:0]  bp;
  logic [31:0] rx;
  int          badCount, totalChecks, cycles, k;
  always #20 clock = ~clock;
  flash_register_command_control #(.MAKER_CODE(8'h5A), .MEMORY_TYPE(8'h11),
    .DENSITY_CODE(8'h22)) dut (.clock(clock), .rst_n(rst_n),
    .csN(csN), .sclk(sclk), .sioIn(sioIn), .sioOut(sioOut), .sioOe(sioOe),
    .resetPinN(resetPinN), .factoryLockStrap(strap), .octalMode(octal),
    .doubleRateOctalMode(dtr), .latencyField(latency),
    .preamblePatternSelect(patSel), .arrayBusy(busy),
    .eraseFailEvt(ev[0]), .programFailEvt(ev[1]), .opSuccessEvt(ev[2]),
    .eraseSuspendEvt(ev[3]), .eraseResumeEvt(ev[4]),
    .programSuspendEvt(ev[5]), .programResumeEvt(ev[6]),
    .opCompleteEvt(ev[7]), .securedOtpMode(otpMode),
    .arrayAccessReq(accessReq), .writeEnableLatch(write_enable_latch),
    .writeInProgressFlag(write_in_progress_flag), .customerLockdownBit(lockdown),
    .otpUpdateAllowed(otpOk), .arrayAccessGrant(grant),
    .blockProtectBits(bp));
  host_spi_model host (.clock(clock), .sioOut(sioOut), .sioOe(sioOe),
    .octal(octal), .csN(csN),
    .sclk(sclk), .sioIn(sioIn));
  // ------
  // Helpers
  // ------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (badCount == 0 && totalChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task cmd(input logic [7:0] c, input logic [23:0] d, input int n);
    host.frame({c, d}, n, rx);
  endtask
  task fire(input logic [7:0] m);
    ev = m;
    @(negedge clock);
    ev = 8'h00;
    repeat (2) @(negedge clock);
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      badCount++;
      conclude;
    end
  end
  initial
  begin
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    cmd(OP_READ_STATUS, 0, 16); chk(rx[7:0], 8'h00);
    chk(host.lastOe, 8'h02);
    chk(sioOe, 8'h00);
    cmd(OP_READ_CONFIG, 0, 16); chk(rx[7:0], 8'h07);
    cmd(OP_READ_SECURITY, 0, 16); chk(rx[7:0], 8'h01);
    cmd(OP_SET_WRITE_LATCH, 0, 8); chk(write_enable_latch, 1);
    cmd(OP_READ_STATUS, 0, 16); chk(rx[7:0], 8'h02);
    cmd(OP_CLEAR_WRITE_LATCH, 0, 8); chk(write_enable_latch, 0);
    cmd(OP_READ_IDENTITY, 0, 32); chk(rx[23:0], 24'h5A_1122);
    busy = 1'b1;
    cmd(OP_READ_IDENTITY, 0, 32); chk(rx[23:0], 0);
    busy = 1'b0;
    cmd(OP_SET_WRITE_LATCH, 0, 8);
    cmd(OP_WRITE_STATUS_CFG, 24'h3C_0000, 12);
    chk({write_in_progress_flag, write_enable_latch, bp}, 6'b01_0000);
    cmd(OP_WRITE_STATUS_CFG, 24'h3F_1700, 24);
    chk({write_in_progress_flag, write_enable_latch, bp}, 6'b11_1111);
    cmd(OP_READ_STATUS, 0, 16); chk(rx[7:0], 8'h3F);
    cmd(OP_READ_CONFIG, 0, 16); chk(rx[7:0], 8'h17);
    for (k = 0; k < 1200 && write_in_progress_flag === 1'b1; k++)
      @(negedge clock);
    chk(k > 600 && k < 1000, 1);
    chk({write_in_progress_flag, write_enable_latch}, 2'b00);
    cmd(OP_READ_STATUS, 0, 16); chk(rx[7:0], 8'h3C);
    // Octal read: opcode byte, six dummy cycles, then the status byte
    octal = 1'b1;
    latency = 3'h7;
    cmd(OP_READ_STATUS, 0, 8);
    chk(host.lastByte, 8'h3C);
    chk(host.lastOe, 8'hFF);
    octal = 1'b0;
    latency = 3'h0;
    fire(8'h2B);
    cmd(OP_READ_SECURITY, 0, 16); chk(rx[7:0], 8'h6D);
    cmd(OP_SET_WRITE_LATCH, 0, 8);
    cmd(OP_WRITE_SECURITY, 0, 8);
    chk({lockdown, otpOk, write_enable_latch}, 3'b100);
    fire(8'h54);
    cmd(OP_READ_SECURITY, 0, 16); chk(rx[7:0], 8'h03);
    cmd(OP_SET_WRITE_LATCH, 0, 8);
    chk(write_enable_latch, 1);
    fire(8'h80); chk(write_enable_latch, 0);
    cmd(OP_SET_WRITE_LATCH, 0, 8);
    chk(write_enable_latch, 1);
    resetPinN = 1'b0;
    repeat (4) @(negedge clock);
    resetPinN = 1'b1;
    chk(write_enable_latch, 0);
    otpMode = 1'b1;
    accessReq = 1'b1;
    repeat (3) @(negedge clock);
    chk(grant, 0);
    otpMode = 1'b0;
    repeat (3) @(negedge clock);
    chk(grant, 1);
    // Second reset with the strap low: factory lock must read clear
    cmd(OP_SET_WRITE_LATCH, 0, 8);
    strap = 1'b0;
    rst_n = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    chk(write_enable_latch, 0);
    cmd(OP_READ_SECURITY, 0, 16);
    chk(rx[0], 1'b0);
    conclude;
  end
endmodule
`default_nettype wire
